/* File: mbd_pkg.sv */
// Package for the serial slave port diagnostics block
package mbd_pkg;
	// Clock and line timing
	localparam int CLK_HZ = 100_000_000;
	localparam int BAUD_4800 = 4800;
	localparam int BAUD_9600 = 9600;
	localparam int BAUD_19200 = 19200;
	localparam int BAUD_38400 = 38400;
	localparam int STOP_BITS = 1;
	localparam int BITS_PARITY = 11;
	localparam int BITS_NO_PARITY = 10;
	localparam int DATA_BITS = 8;
	localparam int SILENCE_CHARS = 3;
	localparam int MAX_FRAME_BYTES = 255;
	// Divider per speed, bit time in clocks
	localparam logic [15:0] DIV_4800 = 16'(CLK_HZ / BAUD_4800);
	localparam logic [15:0] DIV_9600 = 16'(CLK_HZ / BAUD_9600);
	localparam logic [15:0] DIV_19200 = 16'(CLK_HZ / BAUD_19200);
	localparam logic [15:0] DIV_38400 = 16'(CLK_HZ / BAUD_38400);
	// Configuration values
	localparam logic [7:0] ADDR_MIN = 8'h01;
	localparam logic [7:0] ADDR_MAX = 8'hf7;
	localparam logic [7:0] ADDR_DEFAULT = 8'h01;
	localparam logic [7:0] ADDR_BCAST = 8'h00;
	localparam logic [7:0] FC_DIAG = 8'h08;
	localparam logic [7:0] FC_EVCNT = 8'h0b;
	localparam logic [15:0] SUB_ECHO = 16'h0000;
	localparam logic [15:0] SUB_CLEAR = 16'h000a;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'ha001;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam int ACT_HOLD = 2_000_000;
	localparam int FRAME_BITS = 2048;

	typedef enum logic [1:0] {
		MBD_SPD_4800, MBD_SPD_9600, MBD_SPD_19200, MBD_SPD_38400
	} mbd_speed_t;
	typedef enum logic [1:0] {
		MBD_PAR_NONE, MBD_PAR_EVEN, MBD_PAR_ODD
	} mbd_parity_t;
	localparam mbd_speed_t SPEED_DEFAULT = MBD_SPD_38400;
	localparam mbd_parity_t PARITY_DEFAULT = MBD_PAR_ODD;

	// Port configuration bundle
	typedef struct packed {
		logic [7:0]  addr;
		mbd_speed_t  speed;
		mbd_parity_t parity;
		logic        sbo_mode;
	} mbd_cfg_t;
	localparam mbd_cfg_t CFG_DEFAULT = '{ADDR_DEFAULT, SPEED_DEFAULT,
		PARITY_DEFAULT, 1'b0};

	// Diagnostic counter bundle
	typedef struct packed {
		logic [15:0] valid_frame_count;
		logic [15:0] bad_frame_count;
		logic [15:0] exception_reply_count;
		logic [15:0] own_address_frame_count;
		logic [15:0] broadcast_frame_count;
		logic [15:0] char_error_frame_count;
		logic [15:0] executed_request_count;
	} mbd_cnt_t;
endpackage : mbd_pkg

/* File: mbd_port.sv */
// Serial slave port: framing, echo diagnostic and frame counters
// Operation
// RL1: Every character carries exactly one stop bit.
// RL2: With parity, a character is start, eight data, parity, stop.
// RL3: Without parity, a character is start, eight data, stop.
// RL4: Address 1 to 247 default 1, speed, parity none/even/odd default odd.
// RL5: Speed 4800, 9600, 19200 or 38400 baud, default 38400.
// RL6: Remote-control mode: direct (default) or select-before-operate.
// RL7: Changing communication settings restarts the port only.
// RL8: Diagnostic function 8 sub-code 0 echoes the request unchanged; the port echoes only eight-byte requests.
// RL9: Echo replies only when the received CRC checks.
// RL10: Count every valid frame, whichever slave it addresses.
// RL11: Count frames with CRC error, over 255 bytes or bad characters.
// RL12: On 2-wire lines the master ignores the bad frame count.
// RL13: Count every exception generated, even for unsent broadcasts.
// RL14: Count frames addressed to this slave, broadcasts excluded.
// RL15: Count valid broadcast frames.
// RL16: Count frames holding a character with a physical error.
// RL17: Count valid requests received and executed; a host execution and a local frame in one cycle count only once.
// RL18: Counters wrap to zero on reaching 65535.
// RL19: Diagnostic clear command zeroes all counters.
// RL20: Any communication setting change zeroes all counters.
// RL21: Counters readable through functions 8 and 11; the port sends no counter reply, it only counts such frames as executed.
// RL22: Activity output flashes on any line traffic.
// RL23: Silence over three character times starts a new frame.
// RL24: Address zero is broadcast; act on it, never reply.
// RL25: Counters are 16-bit, zero at reset, advance by one.
`timescale 1ns/1ps
module mbd_port
	import mbd_pkg::*;
(
	input  wire logic            clk,          // System clock 100 MHz
	input  wire logic            rst_b,        // Async reset, low
	input  wire mbd_pkg::mbd_cfg_t cfg,        // Port settings
	input  wire logic            rxd,          // Line receive data
	input  wire logic            exec_ok,      // Host executed request
	input  wire logic            exec_exc,     // Host raised exception
	output logic                 txd,          // Line transmit data
	output logic                 tx_en,        // Driver enable
	output logic                 frame_done,   // Good frame for host
	output logic                 sbo_mode,     // Remote-control mode
	output mbd_pkg::mbd_cnt_t    counters,     // Diagnostic counters
	output logic                 activity      // Link activity
);
	import mbd_pkg::*;

	// Bit divider for a speed code
	function automatic logic [15:0] div_of(input mbd_speed_t s);
		case (s)
			MBD_SPD_4800:  div_of = DIV_4800;
			MBD_SPD_9600:  div_of = DIV_9600;
			MBD_SPD_19200: div_of = DIV_19200;
			default:       div_of = DIV_38400;
		endcase
	endfunction : div_of

	// One CRC-16 byte step, reflected polynomial
	function automatic logic [15:0] crc_step(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < DATA_BITS; i++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		crc_step = r;
	endfunction : crc_step

	// Wrap counter by one
	function automatic logic [15:0] bump(input logic [15:0] v);
		bump = (v == CNT_MAX) ? 16'h0000 : v + 16'h0001; // RL18
	endfunction : bump

	// Line-side state machines
	typedef enum {MBD_RX_IDLE, MBD_RX_BITS} mbd_rx_st_t;
	typedef enum {MBD_TX_IDLE, MBD_TX_LOAD, MBD_TX_BITS} mbd_tx_st_t;

	// Configuration shadow for change detection
	mbd_cfg_t    cfg_reg;
	logic        restart;
	assign restart = ({cfg.addr, cfg.speed, cfg.parity} !=
		{cfg_reg.addr, cfg_reg.speed, cfg_reg.parity}); // RL7 RL20

	// Character geometry follows the shadow, so it moves only on restart
	wire logic [15:0] bit_div = div_of(cfg_reg.speed); // RL5
	wire logic        par_on  = (cfg_reg.parity != MBD_PAR_NONE);
	wire logic [3:0]  char_bits = par_on ? 4'(BITS_PARITY)
		: 4'(BITS_NO_PARITY); // RL2 RL3
	wire logic [10:0] silence_bits = 11'(char_bits) * 11'(SILENCE_CHARS);

	// Shadow lags the pins one cycle; the difference is the restart
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) cfg_reg <= CFG_DEFAULT; // RL4
		else cfg_reg <= cfg;
	end

	// Receiver shift state
	mbd_rx_st_t  rx_st_reg;
	logic [15:0] rx_tick_reg;
	logic [3:0]  rx_bit_reg;
	logic [10:0] rx_sh_reg;
	logic [15:0] idle_tick_reg;
	logic [10:0] idle_bits_reg;
	logic        rx_prev_reg;

	wire logic rx_fall = rx_prev_reg & ~rxd;
	wire logic bit_tick = (rx_tick_reg == bit_div - 16'h0001);
	wire logic half_tick = (rx_tick_reg == (bit_div >> 1));
	wire logic char_end = (rx_st_reg == MBD_RX_BITS) && half_tick &&
		(rx_bit_reg == char_bits - 4'h1);
	// Frame shape: start, data LSB first, optional parity, one stop
	wire logic [7:0] rx_byte = rx_sh_reg[8:1];
	// The stop sample reaches the shifter a cycle after char_end,
	// so the pin itself is judged at that cycle
	wire logic stop_bit = rxd; // RL1
	wire logic par_bad  = par_on && ((^rx_sh_reg[9:1]) !=
		(cfg_reg.parity == MBD_PAR_ODD));
	wire logic frm_bad  = ~stop_bit;
	// Break: framing error with an all-zero data byte
	wire logic brk_bad  = frm_bad && (rx_byte == 8'h00);
	wire logic gap_end  = (idle_bits_reg == silence_bits) &&
		(rx_st_reg == MBD_RX_IDLE); // RL23

	// Bit shifter, sampling mid-bit
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_st_reg   <= MBD_RX_IDLE;
			rx_tick_reg <= 16'h0000;
			rx_bit_reg  <= 4'h0;
			rx_sh_reg   <= 11'h000;
			rx_prev_reg <= 1'b1;
		end else begin
			rx_prev_reg <= rxd;
			case (rx_st_reg)
				MBD_RX_IDLE: begin
					rx_tick_reg <= 16'h0000;
					rx_bit_reg  <= 4'h0;
					if (rx_fall && !restart && !tx_en) rx_st_reg <= MBD_RX_BITS;
				end
				MBD_RX_BITS: begin
					rx_tick_reg <= bit_tick ? 16'h0000 : rx_tick_reg + 16'h0001;
					if (half_tick) begin
						rx_sh_reg[rx_bit_reg] <= rxd;
						rx_bit_reg <= rx_bit_reg + 4'h1;
					end
					if (char_end || restart) rx_st_reg <= MBD_RX_IDLE;
				end
				default: rx_st_reg <= MBD_RX_IDLE;
			endcase
		end
	end

	// Silence timer in bit times
	// Timer saturates, so gap_end stays high until the next start bit
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			idle_tick_reg <= 16'h0000;
			idle_bits_reg <= 11'h000;
		end else if (rx_st_reg != MBD_RX_IDLE || restart) begin
			idle_tick_reg <= 16'h0000;
			idle_bits_reg <= 11'h000;
		end else if (idle_bits_reg != silence_bits) begin
			idle_tick_reg <= (idle_tick_reg == bit_div - 16'h0001) ?
				16'h0000 : idle_tick_reg + 16'h0001;
			if (idle_tick_reg == bit_div - 16'h0001)
				idle_bits_reg <= idle_bits_reg + 11'h001;
		end
	end

	// Frame assembly: first bytes kept for decoding and echo
	logic [8:0]  len_reg;
	logic [15:0] crc_reg;
	logic        phys_reg;
	logic        in_frame_reg;
	logic [7:0]  buf_reg [0:7];
	wire logic   len_over = (len_reg > 9'(MAX_FRAME_BYTES));

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			len_reg      <= 9'h000;
			crc_reg      <= CRC_INIT;
			phys_reg     <= 1'b0;
			in_frame_reg <= 1'b0;
			for (int i = 0; i < 8; i++) buf_reg[i] <= 8'h00;
		end else if (restart || gap_end) begin
			len_reg      <= 9'h000;
			crc_reg      <= CRC_INIT;
			phys_reg     <= 1'b0;
			in_frame_reg <= 1'b0;
		end else if (char_end) begin
			in_frame_reg <= 1'b1;
			crc_reg <= crc_step(crc_reg, rx_byte);
			if (!len_over) len_reg <= len_reg + 9'h001;
			if (len_reg < 9'h008) buf_reg[len_reg[2:0]] <= rx_byte;
			if (par_bad || frm_bad || brk_bad) phys_reg <= 1'b1; // RL16
		end
	end

	// Frame classification at silence
	wire logic f_end   = gap_end && in_frame_reg;
	wire logic crc_ok  = (crc_reg == 16'h0000) && (len_reg > 9'h003);
	wire logic f_bad   = ~crc_ok || len_over || phys_reg; // RL11
	wire logic f_valid = ~f_bad;
	wire logic is_bc   = (buf_reg[0] == ADDR_BCAST); // RL24
	wire logic is_own  = (buf_reg[0] == cfg_reg.addr);
	wire logic [15:0] sub_code = {buf_reg[2], buf_reg[3]};
	wire logic is_diag = (buf_reg[1] == FC_DIAG);
	// Only eight-byte echo requests are replayed
	wire logic is_echo = is_diag && (sub_code == SUB_ECHO) &&
		(len_reg == 9'h008);
	wire logic is_clr  = is_diag && (sub_code == SUB_CLEAR);
	wire logic is_evc  = (buf_reg[1] == FC_EVCNT);
	wire logic local_fn = f_valid && is_own && (is_echo || is_evc ||
		is_diag); // RL21

	// Counters: clear first, then events, wrapping at maximum
	// Host execution and a local frame in one cycle count only once
	mbd_cnt_t cnt_reg;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= '0; // RL25
		end else if (restart || (f_end && f_valid && (is_own || is_bc) &&
			is_clr)) begin
			cnt_reg <= '0; // RL19 RL20
		end else begin
			if (f_end && f_valid)
				cnt_reg.valid_frame_count <=
					bump(cnt_reg.valid_frame_count); // RL10
			if (f_end && f_bad)
				cnt_reg.bad_frame_count <= bump(cnt_reg.bad_frame_count); // RL11
			if (exec_exc)
				cnt_reg.exception_reply_count <=
					bump(cnt_reg.exception_reply_count); // RL13
			if (f_end && f_valid && is_own)
				cnt_reg.own_address_frame_count <=
					bump(cnt_reg.own_address_frame_count); // RL14
			if (f_end && f_valid && is_bc)
				cnt_reg.broadcast_frame_count <=
					bump(cnt_reg.broadcast_frame_count); // RL15
			if (f_end && phys_reg)
				cnt_reg.char_error_frame_count <=
					bump(cnt_reg.char_error_frame_count); // RL16
			if (exec_ok || (f_end && local_fn))
				cnt_reg.executed_request_count <=
					bump(cnt_reg.executed_request_count); // RL17
		end
	end
	assign counters = cnt_reg;

	// Host gets every good own-address or broadcast frame not served locally
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) frame_done <= 1'b0;
		else frame_done <= f_end && f_valid && (is_own || is_bc) &&
			!local_fn; // RL24
	end

	// Mode is a plain level for the host's command logic
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) sbo_mode <= 1'b0;
		else sbo_mode <= cfg.sbo_mode; // RL6
	end

	// Echo transmitter: replays the eight stored bytes
	mbd_tx_st_t  tx_st_reg;
	logic [2:0]  tx_idx_reg;
	logic [3:0]  tx_bit_reg;
	logic [15:0] tx_tick_reg;
	logic [10:0] tx_sh_reg;
	wire logic   start_echo = f_end && f_valid && is_own && is_echo; // RL8 RL9
	wire logic [7:0] tx_byte = buf_reg[tx_idx_reg];
	wire logic   tx_par = (^tx_byte) ^ (cfg_reg.parity == MBD_PAR_ODD);
	wire logic [10:0] tx_word = par_on ? {1'b1, tx_par, tx_byte, 1'b0}
		: {2'b11, tx_byte, 1'b0}; // RL1 RL2 RL3
	wire logic   tx_tick = (tx_tick_reg == bit_div - 16'h0001);
	wire logic   tx_last = tx_tick && (tx_bit_reg == char_bits - 4'h1);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_st_reg   <= MBD_TX_IDLE;
			tx_idx_reg  <= 3'h0;
			tx_bit_reg  <= 4'h0;
			tx_tick_reg <= 16'h0000;
			tx_sh_reg   <= 11'h7ff;
		end else if (restart) begin
			tx_st_reg <= MBD_TX_IDLE;
			tx_sh_reg <= 11'h7ff;
		end else begin
			case (tx_st_reg)
				MBD_TX_IDLE: begin
					tx_idx_reg <= 3'h0;
					if (start_echo) tx_st_reg <= MBD_TX_LOAD;
				end
				MBD_TX_LOAD: begin
					tx_sh_reg   <= tx_word;
					tx_bit_reg  <= 4'h0;
					tx_tick_reg <= 16'h0000;
					tx_st_reg   <= MBD_TX_BITS;
				end
				MBD_TX_BITS: begin
					tx_tick_reg <= tx_tick ? 16'h0000 : tx_tick_reg + 16'h0001;
					if (tx_tick) begin
						tx_sh_reg  <= {1'b1, tx_sh_reg[10:1]};
						tx_bit_reg <= tx_bit_reg + 4'h1;
					end
					if (tx_last) begin
						tx_idx_reg <= tx_idx_reg + 3'h1;
						tx_st_reg  <= (tx_idx_reg == 3'h7) ? MBD_TX_IDLE
							: MBD_TX_LOAD;
					end
				end
				default: tx_st_reg <= MBD_TX_IDLE;
			endcase
		end
	end

	// Line driver registered so pins come from flops
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			txd   <= 1'b1;
			tx_en <= 1'b0;
		end else begin
			txd   <= tx_sh_reg[0];
			// Enable rises with the start bit, not with the first load
			tx_en <= (tx_st_reg == MBD_TX_BITS) ||
				(tx_st_reg == MBD_TX_LOAD && tx_idx_reg != 3'h0);
		end
	end

	// Activity stretch so short frames stay visible
	logic [20:0] act_cnt_reg;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			act_cnt_reg <= 21'h000000;
			activity    <= 1'b0;
		end else begin
			if (rx_st_reg != MBD_RX_IDLE || tx_st_reg != MBD_TX_IDLE)
				act_cnt_reg <= 21'(ACT_HOLD); // RL22
			else if (act_cnt_reg != 21'h000000)
				act_cnt_reg <= act_cnt_reg - 21'h000001;
			activity <= (act_cnt_reg != 21'h000000);
		end
	end
endmodule : mbd_port

/* File: mbd_checker.sv */
// Port assertions for the serial slave port
`timescale 1ns/1ps
module mbd_checker
	import mbd_pkg::*;
(
	input wire logic              clk,        // Clock
	input wire logic              rst_b,      // Reset, low
	input wire mbd_pkg::mbd_cfg_t cfg,        // Settings
	input wire logic              rxd,        // Line in
	input wire logic              exec_ok,    // Executed
	input wire logic              exec_exc,   // Exception
	input wire logic              txd,        // Line out
	input wire logic              tx_en,      // Driver on
	input wire logic              frame_done, // Frame pulse
	input wire logic              sbo_mode,   // Mode copy
	input wire mbd_pkg::mbd_cnt_t counters,   // Counters
	input wire logic              activity    // Activity
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Short names for the watched counters
	wire [15:0] c_ok  = counters.executed_request_count;
	wire [15:0] c_exc = counters.exception_reply_count;
	wire [15:0] c_val = counters.valid_frame_count;
	// Wrap or clear gives zero, anything else is one step
	AST_EXEC_STEP: assert property ($changed(c_ok) |->
		c_ok == 16'($past(c_ok) + 1) || c_ok == 16'h0000)
		else $error("executed count jumped");
	AST_VALID_STEP: assert property ($changed(c_val) |->
		c_val == 16'($past(c_val) + 1) || c_val == 16'h0000)
		else $error("valid count jumped");
	AST_EXC_BUMP: assert property (exec_exc && $stable(cfg) |=>
		c_exc == 16'($past(c_exc) + 1))
		else $error("exception count missed");
	AST_FRAME_PULSE: assert property (frame_done |=> !frame_done)
		else $error("frame pulse too long");
	AST_IDLE_HIGH: assert property (!tx_en |-> txd)
		else $error("line out not idle");
	AST_START_BIT: assert property ($rose(tx_en) |-> !txd)
		else $error("reply lacks start bit");
	AST_SBO_COPY: assert property (1'b1 |=>
		sbo_mode == $past(cfg.sbo_mode))
		else $error("mode output stale");
	AST_CFG_CLEAR: assert property ($changed(cfg.addr) |->
		##[1:2] counters == '0)
		else $error("counters kept on setting change");
	AST_ACT: assert property (tx_en |=> activity)
		else $error("no activity while sending");
endmodule : mbd_checker
bind mbd_port mbd_checker u_chk (.clk, .rst_b, .cfg, .rxd, .exec_ok,
	.exec_exc, .txd, .tx_en, .frame_done, .sbo_mode, .counters, .activity);

/* File: mbd_master.sv */
// Line master model: sends requests, collects reply bytes
`timescale 1ns/1ps
module mbd_master
	import mbd_pkg::*;
(
	input  wire logic clk,   // Clock
	input  wire logic txd,   // Slave reply
	input  wire logic tx_en, // Slave driver on
	output logic      rxd    // Request line
);
	localparam int BIT = int'(DIV_38400);
	logic [7:0] rx_q[$];
	logic [7:0] b;
	// Polarised line rests high between frames
	initial rxd = 1'b1;
	// Start, data LSB first, odd parity, one stop bit
	task automatic send(input logic [7:0] q[$], input logic perr);
		logic [10:0] f;
		foreach (q[j]) begin
			f = {1'b1, ~^q[j] ^ (perr && j == 0), q[j], 1'b0};
			for (int i = 0; i < 11; i++) begin
				rxd <= f[i];
				repeat (BIT) @(posedge clk);
			end
		end
		// Four characters of quiet, more than the minimum
		repeat (BIT * 44) @(posedge clk);
	endtask : send
	// Reply receiver; the bad frame count is never consulted
	always begin
		@(posedge clk iff (tx_en === 1'b1 && txd === 1'b0));
		repeat (BIT / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge clk);
			b[i] = txd;
		end
		repeat (BIT * 2) @(posedge clk);
		rx_q.push_back(b);
	end
endmodule : mbd_master

/* File: tb_mbd_port.sv */
// Self-checking bench for the serial slave port
`timescale 1ns/1ps
module tb_mbd_port;
	import mbd_pkg::*;
	typedef struct {
		logic        ok;
		logic        exc;
		logic [15:0] n_ok;
		logic [15:0] n_exc;
	} mbd_row_t;
	localparam int CHR = int'(DIV_38400) * 11;
	logic       clk      = 1'b0;
	logic       rst_b    = 1'b0;
	mbd_cfg_t   cfg      = CFG_DEFAULT;
	logic       exec_ok  = 1'b0;
	logic       exec_exc = 1'b0;
	logic       rxd, txd, tx_en, frame_done, sbo_mode, activity;
	logic       tx_seen, fd_seen;
	mbd_cnt_t   counters, e;
	logic [7:0] q[$];
	int         fail_count = 0;
	int         cmp_count = 0;
	int         cyc = 0;
	mbd_row_t   rows[3] = '{'{1, 0, 1, 0}, '{0, 1, 1, 1}, '{1, 1, 2, 2}};

	always #5 clk = ~clk;
	mbd_port dut (.clk, .rst_b, .cfg, .rxd, .exec_ok, .exec_exc, .txd,
		.tx_en, .frame_done, .sbo_mode, .counters, .activity);
	mbd_master master (.clk, .txd, .tx_en, .rxd);

	// Sticky flags, plus a cycle limit against hangs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (tx_en === 1'b1) tx_seen <= 1'b1;
		if (frame_done === 1'b1) fd_seen <= 1'b1;
		if (cyc == 2_500_000) begin
			fail_count++;
			end_sim();
		end
	end

	task automatic chk(input string n, input logic [15:0] x,
		input logic [15:0] g);
		cmp_count++;
		if (g !== x) begin
			fail_count++;
			$display("CHECK FAILED %s exp %h got %h", n, x, g);
		end
	endtask : chk
	// All seven counters against the expected bundle
	task automatic cnts(input mbd_cnt_t x);
		for (int i = 0; i < 7; i++)
			chk($sformatf("counter %0d", i), x[i*16+:16], counters[i*16+:16]);
	endtask : cnts
	task automatic end_sim();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim
	// Bench's own CRC, low byte sent first
	function automatic void add_crc(inout logic [7:0] f[$]);
		logic [15:0] c;
		c = CRC_INIT;
		foreach (f[i]) begin
			c ^= {8'h00, f[i]};
			for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
		end
		f.push_back(c[7:0]);
		f.push_back(c[15:8]);
	endfunction : add_crc
	// One request; waits out any reply under a bound
	task automatic frame(input logic perr);
		@(negedge clk);
		tx_seen = 1'b0;
		fd_seen = 1'b0;
		master.rx_q.delete();
		@(posedge clk);
		master.send(q, perr);
		for (int i = 0; i < CHR * 9 && tx_en !== 1'b0; i++) @(posedge clk);
		repeat (3) @(negedge clk);
	endtask : frame

	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		e = '0;
		cnts(e);
		chk("txd", 16'h0001, 16'(txd));
		chk("sbo", 16'h0000, 16'(sbo_mode));
		foreach (rows[i]) begin
			@(posedge clk);
			exec_ok <= rows[i].ok;
			exec_exc <= rows[i].exc;
			@(posedge clk);
			exec_ok <= 1'b0;
			exec_exc <= 1'b0;
			repeat (3) @(negedge clk);
			chk("exec", rows[i].n_ok, counters.executed_request_count);
			chk("exc", rows[i].n_exc, counters.exception_reply_count);
		end
		$display("test pulses done");
		e.executed_request_count = 16'h0002;
		e.exception_reply_count = 16'h0002;
		q = '{8'h01, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34, 8'hed, 8'h7c};
		frame(1'b0);
		chk("reply len", 16'h0008, 16'(master.rx_q.size()));
		foreach (q[i]) chk("reply", 16'(q[i]), 16'(master.rx_q[i]));
		chk("activity", 16'h0001, 16'(activity));
		e.valid_frame_count++;
		e.own_address_frame_count++;
		e.executed_request_count++;
		cnts(e);
		$display("test echo done");
		q[7] = 8'h7d;
		frame(1'b0);
		chk("tx silent", 16'h0000, 16'(tx_seen));
		e.bad_frame_count++;
		cnts(e);
		$display("test bad crc done");
		q = '{8'h00, 8'h06, 8'h0c, 8'h00, 8'h12, 8'h34};
		add_crc(q);
		frame(1'b0);
		chk("bcast tx", 16'h0000, 16'(tx_seen));
		chk("bcast pulse", 16'h0001, 16'(fd_seen));
		e.valid_frame_count++;
		e.broadcast_frame_count++;
		cnts(e);
		frame(1'b1);
		chk("parity pulse", 16'h0000, 16'(fd_seen));
		e.bad_frame_count++;
		e.char_error_frame_count++;
		cnts(e);
		$display("test broadcast and parity done");
		@(posedge clk);
		cfg.addr <= 8'h02;
		cfg.sbo_mode <= 1'b1;
		repeat (3) @(negedge clk);
		cnts('0);
		chk("sbo", 16'h0001, 16'(sbo_mode));
		$display("test settings done");
		// Diagnostic clear to the new address after one exception
		@(posedge clk);
		exec_exc <= 1'b1;
		@(posedge clk);
		exec_exc <= 1'b0;
		@(negedge clk);
		chk("exc", 16'h0001, counters.exception_reply_count);
		q = '{8'h02, 8'h08, 8'h00, 8'h0a, 8'h00, 8'h00};
		add_crc(q);
		frame(1'b0);
		chk("clear pulse", 16'h0000, 16'(fd_seen));
		cnts('0);
		$display("test clear done");
		end_sim();
	end
endmodule : tb_mbd_port
